// ### hw/pca_decoder.sv
// Purpose: Host I/O front end of configuration mechanism one: selector, data
//   window, routing of configuration cycles and pass-through of other I/O.
// Assumes: Host holds io_req_i until io_ack_o; targets hold done for one cycle.
// Notes: One request is in flight at a time; all data outputs are registered.
//
// How it works
// - Byte, word and dword host accesses accepted; selector only as full dword.
// - Byte enable n maps to data bits 8n+7:8n, little-endian order.
// - Partial access at the selector location is forwarded as plain I/O.
// - Selector is 32 bits at 0CF8h, dword only, reset to zero.
// - Data window passes byte, word or dword reads and writes to selected dword.
// - Configuration through the window only while selector bit 31 is set.
// - Selector bits 30:24 are read-only zero.
// - Bus zero goes to an internal device or the hub by device number.
// - Bus zero, non-internal device: Type 0 cycle on the hub link.
// - Bus outside downstream range: Type 1 cycle on the hub link.
// - Bus equal first downstream index: Type 0 cycle on graphics port.
// - Bus above first, up to last index: Type 1 cycle on graphics port.
// - Type 1 cycles carry device number on AD15:11.
// - Type 0 cycles drive one select line among AD31:11; hub devices above 20 get none.
// - Internal devices are fixed at numbers 0, 1 and 2 on bus zero.
// - Graphics port Type 0 select: line 16 plus device number.
// - Graphics port Type 0 device above 15: no select, master abort recorded.
// - Device number on hub A15:11 and graphics port Type 1 AD15:11.
// - Function number goes onto AD10:8.
// - Internal devices claim function zero only; others master abort.
// - Register number drives AD7:2.
// - Data window sits at 0CFCh and uses the selector while enabled.
// - Internal device cycles stay off the hub; devices 3 to 31 go over it.
`default_nettype none
module pca_decoder
  import pca_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic io_req_i,
  input wire logic io_wr_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [3:0] io_be_i,
  input wire logic [31:0] io_wdata_i,
  output logic io_ack_o,
  output logic [31:0] io_rdata_o,
  input wire logic [7:0] first_downstream_bus_index_i,
  input wire logic [7:0] last_downstream_bus_index_i,
  output logic cyc_req_o,
  output logic cyc_wr_o,
  output logic [1:0] cyc_tgt_o,
  output logic cyc_type1_o,
  output logic [4:0] cyc_dev_o,
  output logic [31:0] cyc_addr_o,
  output logic [20:0] cyc_idsel_o,
  output logic [3:0] cyc_be_o,
  output logic [31:0] cyc_wdata_o,
  input wire logic cyc_done_i,
  input wire logic [31:0] cyc_rdata_i,
  output logic fwd_req_o,
  output logic fwd_wr_o,
  output logic [15:0] fwd_addr_o,
  output logic [3:0] fwd_be_o,
  output logic [31:0] fwd_wdata_o,
  input wire logic fwd_done_i,
  input wire logic [31:0] fwd_rdata_i,
  output logic cfg_access_enable_o,
  output logic cfg_mabort_o,
  output logic gp_mabort_o
);
  pca_route_if rif();
  pca_state_t state_r;
  pca_state_t state_nxt;
  logic at_sel;
  logic at_win;
  logic sel_hit;
  logic win_hit;
  logic take;
  logic sel_wr;
  logic [31:0] rdata_r;
  logic cyc_req_r;
  logic fwd_req_r;
  logic cfg_mabort_r;
  logic gp_mabort_r;

  ////////////////////////////////////////////////////////////////////////////
  // Selector and route decode.

  assign rif.first_bus = first_downstream_bus_index_i;
  assign rif.last_bus = last_downstream_bus_index_i;

  pca_sel_reg u_sel (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .wr_i(sel_wr),
    .wdata_i(io_wdata_i),
    .rif(rif)
  );

  pca_route u_route (
    .rif(rif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Host address decode.

  // Dword locations compared on address bits 15:2; lanes come from byte enables.
  assign at_sel = io_addr_i[PCA_IO_DW_MSB:PCA_IO_DW_LSB] == PCA_SEL_IO_ADDR[PCA_IO_DW_MSB:PCA_IO_DW_LSB];
  assign at_win = io_addr_i[PCA_IO_DW_MSB:PCA_IO_DW_LSB] == PCA_WIN_IO_ADDR[PCA_IO_DW_MSB:PCA_IO_DW_LSB];
  assign sel_hit = at_sel && (io_be_i == PCA_BE_DWORD);
  assign win_hit = at_win && rif.sel[PCA_SEL_EN_BIT];
  assign take = (state_r == PCA_ST_IDLE) && io_req_i;
  assign sel_wr = take && sel_hit && io_wr_i;

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer.

  // Chooses between local selector access, configuration cycle and pass-through.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PCA_ST_IDLE: begin
        if (io_req_i) begin
          if (sel_hit) begin
            state_nxt = PCA_ST_ACK;
          end else if (win_hit) begin
            state_nxt = (rif.tgt == PCA_TGT_ABORT) ? PCA_ST_ACK : PCA_ST_CFG;
          end else begin
            state_nxt = PCA_ST_FWD;
          end
        end
      end
      PCA_ST_CFG: begin
        if (cyc_done_i) begin
          state_nxt = PCA_ST_ACK;
        end
      end
      PCA_ST_FWD: begin
        if (fwd_done_i) begin
          state_nxt = PCA_ST_ACK;
        end
      end
      PCA_ST_ACK: begin
        state_nxt = PCA_ST_IDLE;
      end
    endcase
  end

  // Holds the sequencer state.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state_r <= PCA_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data returned to the host.

  // Captures the selector, an aborted read pattern, or target read data.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rdata_r <= PCA_ZERO_DATA;
    end else if (take && sel_hit) begin
      rdata_r <= rif.sel;
    end else if (take && win_hit && rif.tgt == PCA_TGT_ABORT) begin
      rdata_r <= PCA_ABORT_DATA;
    end else if (state_r == PCA_ST_CFG && cyc_done_i) begin
      rdata_r <= cyc_rdata_i;
    end else if (state_r == PCA_ST_FWD && fwd_done_i) begin
      rdata_r <= fwd_rdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration cycle request.

  // Latches the decoded cycle and holds the request until the target is done.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cyc_req_r <= 1'b0;
      cyc_wr_o <= 1'b0;
      cyc_tgt_o <= PCA_TGT_INT;
      cyc_type1_o <= 1'b0;
      cyc_dev_o <= PCA_DEV_HOST_BRIDGE;
      cyc_addr_o <= PCA_ZERO_DATA;
      cyc_idsel_o <= '0;
      cyc_be_o <= '0;
      cyc_wdata_o <= PCA_ZERO_DATA;
    end else if (take && win_hit && rif.tgt != PCA_TGT_ABORT) begin
      cyc_req_r <= 1'b1;
      cyc_wr_o <= io_wr_i;
      cyc_tgt_o <= rif.tgt;
      cyc_type1_o <= rif.type1;
      cyc_dev_o <= rif.sel[PCA_DEV_MSB:PCA_DEV_LSB];
      cyc_addr_o <= rif.ad;
      cyc_idsel_o <= rif.idsel;
      cyc_be_o <= io_be_i;
      cyc_wdata_o <= io_wdata_i;
    end else if (state_r == PCA_ST_CFG && cyc_done_i) begin
      cyc_req_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pass-through I/O cycle on the primary expansion bus.

  // Forwards anything that is not a dword selector access or an enabled window access.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      fwd_req_r <= 1'b0;
      fwd_wr_o <= 1'b0;
      fwd_addr_o <= '0;
      fwd_be_o <= '0;
      fwd_wdata_o <= PCA_ZERO_DATA;
    end else if (take && !sel_hit && !win_hit) begin
      fwd_req_r <= 1'b1;
      fwd_wr_o <= io_wr_i;
      fwd_addr_o <= io_addr_i;
      fwd_be_o <= io_be_i;
      fwd_wdata_o <= io_wdata_i;
    end else if (state_r == PCA_ST_FWD && fwd_done_i) begin
      fwd_req_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master abort reports.

  // One-cycle pulses; the graphics port one feeds the virtual bridge status.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cfg_mabort_r <= 1'b0;
      gp_mabort_r <= 1'b0;
    end else begin
      cfg_mabort_r <= take && win_hit && rif.tgt == PCA_TGT_ABORT;
      gp_mabort_r <= take && win_hit && rif.gp_no_idsel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign io_ack_o = (state_r == PCA_ST_ACK);
  assign io_rdata_o = rdata_r;
  assign cyc_req_o = cyc_req_r;
  assign fwd_req_o = fwd_req_r;
  assign cfg_access_enable_o = rif.sel[PCA_SEL_EN_BIT];
  assign cfg_mabort_o = cfg_mabort_r;
  assign gp_mabort_o = gp_mabort_r;
endmodule
`default_nettype wire

// ### hw/pca_pkg.sv
// Purpose: Shared constants and types for the configuration access decoder.
// Assumes: Host I/O addresses are byte addresses; lanes are selected by byte enables.
// Notes: All offsets, field positions and reset values of the block live here.
`default_nettype none
package pca_pkg;
  // Host I/O locations of the selector and of the data window (dword aligned).
  localparam logic [15:0] PCA_SEL_IO_ADDR = 16'h0CF8;
  localparam logic [15:0] PCA_WIN_IO_ADDR = 16'h0CFC;
  localparam int PCA_IO_DW_LSB = 2;
  localparam int PCA_IO_DW_MSB = 15;
  // Selector layout and reset value.
  localparam logic [31:0] PCA_SEL_RESET = 32'h0000_0000;
  localparam logic [31:0] PCA_SEL_WR_MASK = 32'h80FF_FFFC;
  localparam int PCA_SEL_EN_BIT = 31;
  localparam int PCA_BUS_MSB = 23;
  localparam int PCA_BUS_LSB = 16;
  localparam int PCA_DEV_MSB = 15;
  localparam int PCA_DEV_LSB = 11;
  localparam int PCA_FN_MSB = 10;
  localparam int PCA_FN_LSB = 8;
  localparam int PCA_REG_MSB = 7;
  localparam int PCA_REG_LSB = 2;
  // Fixed device numbers of the internal functions on bus zero.
  localparam logic [4:0] PCA_DEV_HOST_BRIDGE = 5'h00;
  localparam logic [4:0] PCA_DEV_GPORT_BRIDGE = 5'h01;
  localparam logic [4:0] PCA_DEV_INTEGRATED_GRAPHICS = 5'h02;
  localparam logic [2:0] PCA_FN_ZERO = 3'h0;
  localparam logic [7:0] PCA_BUS_ZERO = 8'h00;
  // One-hot select limits: hub covers AD[31:11], graphics port GRAPHICS_PORT_AD_LINES[31:16].
  localparam int PCA_IDSEL_W = 21;
  localparam logic [4:0] PCA_HUB_MAX_DEV = 5'h14;
  localparam logic [4:0] PCA_GP_MAX_DEV = 5'h0F;
  localparam int PCA_GP_IDSEL_OFS = 5;
  // Cycle type code carried in AD[1:0].
  localparam logic [1:0] PCA_AD_TYPE0 = 2'h0;
  localparam logic [1:0] PCA_AD_TYPE1 = 2'h1;
  localparam logic [3:0] PCA_BE_DWORD = 4'hF;
  localparam logic [31:0] PCA_ABORT_DATA = 32'hFFFF_FFFF;
  localparam logic [31:0] PCA_ZERO_DATA = 32'h0000_0000;

  // Destination of a data window access.
  typedef enum logic [1:0] {
    PCA_TGT_INT = 2'h0,
    PCA_TGT_HUB = 2'h1,
    PCA_TGT_GP = 2'h2,
    PCA_TGT_ABORT = 2'h3
  } pca_tgt_t;

  // Host access sequencer, Gray coded along idle, cycle, acknowledge.
  typedef enum logic [1:0] {
    PCA_ST_IDLE = 2'b00,
    PCA_ST_CFG = 2'b01,
    PCA_ST_ACK = 2'b11,
    PCA_ST_FWD = 2'b10
  } pca_state_t;
endpackage
`default_nettype wire

// ### hw/pca_route.sv
// Purpose: Decodes the selector into a destination, cycle type and address word.
// Assumes: Downstream bus bounds come from the graphics port bridge registers.
// Notes: Purely combinational; the top registers everything it drives out.
`default_nettype none
module pca_route
  import pca_pkg::*;
(
  pca_route_if.router rif
);
  logic [7:0] bus;
  logic [4:0] dev;
  logic [2:0] fn;
  logic [5:0] regn;
  logic [PCA_IDSEL_W-1:0] onehot;

  assign bus = rif.sel[PCA_BUS_MSB:PCA_BUS_LSB];
  assign dev = rif.sel[PCA_DEV_MSB:PCA_DEV_LSB];
  assign fn = rif.sel[PCA_FN_MSB:PCA_FN_LSB];
  assign regn = rif.sel[PCA_REG_MSB:PCA_REG_LSB];

  // One select line per device number, AD[11+n]; none beyond the top line.
  for (genvar i = 0; i < PCA_IDSEL_W; i++) begin : g_idsel
    assign onehot[i] = (dev == 5'(i));
  end

  // Chooses destination and type from bus and device number.
  always_comb begin
    rif.tgt = PCA_TGT_HUB;
    rif.type1 = 1'b0;
    rif.gp_no_idsel = 1'b0;
    if (bus == PCA_BUS_ZERO) begin
      if (dev == PCA_DEV_HOST_BRIDGE || dev == PCA_DEV_GPORT_BRIDGE
          || dev == PCA_DEV_INTEGRATED_GRAPHICS) begin
        rif.tgt = (fn == PCA_FN_ZERO) ? PCA_TGT_INT : PCA_TGT_ABORT;
      end else begin
        rif.tgt = PCA_TGT_HUB;
      end
    end else if (bus == rif.first_bus) begin
      rif.tgt = PCA_TGT_GP;
      if (dev > PCA_GP_MAX_DEV) begin
        rif.tgt = PCA_TGT_ABORT;
        rif.gp_no_idsel = 1'b1;
      end
    end else if (bus < rif.first_bus || bus > rif.last_bus) begin
      rif.tgt = PCA_TGT_HUB;
      rif.type1 = 1'b1;
    end else begin
      rif.tgt = PCA_TGT_GP;
      rif.type1 = 1'b1;
    end
  end

  // Builds the address word: register, function, then device field or select.
  always_comb begin
    rif.ad = PCA_ZERO_DATA;
    rif.idsel = '0;
    rif.ad[PCA_REG_MSB:PCA_REG_LSB] = regn;
    rif.ad[PCA_FN_MSB:PCA_FN_LSB] = fn;
    if (rif.type1) begin
      rif.ad[1:0] = PCA_AD_TYPE1;
      rif.ad[PCA_BUS_MSB:PCA_BUS_LSB] = bus;
      rif.ad[PCA_DEV_MSB:PCA_DEV_LSB] = dev;
    end else if (rif.tgt == PCA_TGT_GP) begin
      rif.ad[1:0] = PCA_AD_TYPE0;
      rif.idsel = onehot;
      // Device n raises line 16 + n, so the select is shifted up past the device field.
      rif.ad[31:PCA_DEV_LSB+PCA_GP_IDSEL_OFS] = onehot[PCA_IDSEL_W-PCA_GP_IDSEL_OFS-1:0];
    end else begin
      rif.ad[1:0] = PCA_AD_TYPE0;
      rif.idsel = onehot;
      rif.ad[PCA_DEV_MSB:PCA_DEV_LSB] = dev;
    end
  end
endmodule
`default_nettype wire

// ### hw/pca_route_if.sv
// Purpose: Carries the selector and its decoded route between the decoder parts.
// Assumes: One instance inside the top module.
// Notes: The selector owner drives sel; the router drives the decode results.
`default_nettype none
interface pca_route_if;
  import pca_pkg::*;
  logic [31:0] sel;
  logic [7:0] first_bus;
  logic [7:0] last_bus;
  pca_tgt_t tgt;
  logic type1;
  logic gp_no_idsel;
  logic [31:0] ad;
  logic [PCA_IDSEL_W-1:0] idsel;

  modport owner (output sel);
  modport router (input sel, input first_bus, input last_bus,
                  output tgt, output type1, output gp_no_idsel, output ad, output idsel);
endinterface
`default_nettype wire

// ### hw/pca_sel_reg.sv
// Purpose: Holds the configuration target selector.
// Assumes: The caller only pulses wr_i for full dword writes.
// Notes: Read-only and reserved bits are never stored and read as zero.
`default_nettype none
module pca_sel_reg
  import pca_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic wr_i,
  input wire logic [31:0] wdata_i,
  pca_route_if.owner rif
);
  logic [31:0] sel_r;

  // Stores the writable fields; bits 30:24 and 1:0 stay zero.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sel_r <= PCA_SEL_RESET;
    end else if (wr_i) begin
      sel_r <= wdata_i & PCA_SEL_WR_MASK;
    end
  end

  assign rif.sel = sel_r;
endmodule
`default_nettype wire

// ### test/pca_decoder_assertions.sv
// Purpose: Concurrent checks on the ports of the configuration access decoder.
// Assumes: The host aligns addresses and holds each request until acknowledge.
// Notes: A shadow selector is rebuilt from dword writes seen at 0CF8h.
`default_nettype none
module pca_decoder_assertions (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic io_req_i,
  input wire logic io_wr_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [3:0] io_be_i,
  input wire logic [31:0] io_wdata_i,
  input wire logic io_ack_o,
  input wire logic cyc_req_o,
  input wire logic [1:0] cyc_tgt_o,
  input wire logic cyc_type1_o,
  input wire logic [4:0] cyc_dev_o,
  input wire logic [31:0] cyc_addr_o,
  input wire logic [20:0] cyc_idsel_o,
  input wire logic cyc_done_i,
  input wire logic fwd_req_o,
  input wire logic fwd_done_i,
  input wire logic cfg_access_enable_o,
  input wire logic cfg_mabort_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] sel_r;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////
  // Shadow selector; rewriting the same held value is harmless.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sel_r <= 32'h0000_0000;
    end else if (io_req_i && io_wr_i && io_addr_i == 16'h0CF8 && io_be_i == 4'hF) begin
      sel_r <= io_wdata_i & 32'h80FF_FFFC;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  a_ack_single_pulse: assert property (io_ack_o |=> !io_ack_o)
    else $error("acknowledge longer than one cycle");
  a_enable_tracks_sel: assert property (cfg_access_enable_o == sel_r[31])
    else $error("enable output differs from selector bit 31");
  a_fn_reg_copy: assert property (cyc_req_o |-> cyc_addr_o[10:2] == sel_r[10:2])
    else $error("function or register field not copied");
  a_dev_number_copy: assert property (cyc_req_o |-> cyc_dev_o == sel_r[15:11])
    else $error("device number output differs from selector");
  a_type1_fields: assert property (cyc_req_o && cyc_type1_o |->
    cyc_addr_o[23:11] == sel_r[23:11] && cyc_addr_o[1:0] == 2'h1 && cyc_idsel_o == 21'h0)
    else $error("type 1 address word wrong");
  a_hub_idsel: assert property (cyc_req_o && !cyc_type1_o && cyc_tgt_o == 2'h1 |->
    cyc_idsel_o == (21'h1 << sel_r[15:11]) && cyc_addr_o[15:11] == sel_r[15:11])
    else $error("hub type 0 select wrong");
  a_gp_idsel: assert property (cyc_req_o && !cyc_type1_o && cyc_tgt_o == 2'h2 |->
    cyc_addr_o[31:11] == {(16'h1 << sel_r[15:11]), 5'h00})
    else $error("graphics port select line wrong");
  a_bus0_split: assert property (cyc_req_o && sel_r[23:16] == 8'h00 |->
    cyc_tgt_o == ((sel_r[15:11] <= 5'h02) ? 2'h0 : 2'h1))
    else $error("bus zero target wrong");
  a_internal_abort: assert property ($rose(io_req_i) && io_addr_i == 16'h0CFC && sel_r[31]
    && sel_r[23:16] == 8'h00 && sel_r[15:11] <= 5'h02 && sel_r[10:8] != 3'h0
    |=> io_ack_o && cfg_mabort_o && !cyc_req_o)
    else $error("nonzero function to internal device not aborted");
  a_disabled_fwd: assert property ($rose(io_req_i) && io_addr_i == 16'h0CFC && !sel_r[31]
    |=> fwd_req_o && !cyc_req_o)
    else $error("disabled window access not forwarded");
  a_partial_sel_fwd: assert property ($rose(io_req_i) && io_addr_i == 16'h0CF8 && io_be_i != 4'hF
    |=> fwd_req_o)
    else $error("partial selector access not forwarded");
  a_done_to_ack: assert property (cyc_done_i |=> !cyc_req_o && io_ack_o)
    else $error("configuration completion not acknowledged");
  // Main scenarios reached.
  c_abort: cover property (cfg_mabort_o);
  c_gp_type1: cover property (cyc_req_o && cyc_type1_o && cyc_tgt_o == 2'h2);
  c_fwd_done: cover property (fwd_done_i ##1 io_ack_o);
endmodule
bind pca_decoder pca_decoder_assertions i_pca_decoder_assertions (.clk_sys_i, .resetn_i, .io_req_i,
  .io_wr_i, .io_addr_i, .io_be_i, .io_wdata_i, .io_ack_o, .cyc_req_o, .cyc_tgt_o, .cyc_type1_o, .cyc_dev_o,
  .cyc_addr_o, .cyc_idsel_o, .cyc_done_i, .fwd_req_o, .fwd_done_i, .cfg_access_enable_o, .cfg_mabort_o);
`default_nettype wire

// ### test/pca_tgt_model.sv
// Purpose: Target model that answers configuration or pass-through cycles.
// Assumes: The decoder holds the request and its fields until the edge after done.
// Notes: Read data is KEY xor the cycle's tag so the bench can check the routing.
`default_nettype none
module pca_tgt_model #(
  parameter logic [31:0] KEY = 32'h0000_0000
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic [17:0] tag_i,
  input wire logic [31:0] wdata_i,
  input wire logic [2:0] lat_i,
  output logic done_o,
  output logic [31:0] rdata_o,
  output logic [31:0] wlast_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] cnt_r;
  logic seen_r;
  ////////////////////////////////////////////////////////////////////////
  // Waits lat_i cycles on a held request, then pulses done once for it.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cnt_r <= 3'h0;
      seen_r <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= req_i && !seen_r && cnt_r == lat_i;
      if (!req_i) begin
        cnt_r <= 3'h0;
        seen_r <= 1'b0;
      end else if (!seen_r && cnt_r == lat_i) begin
        seen_r <= 1'b1;
      end else if (!seen_r) begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end
  // Keeps the write data of the last completed write.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      wlast_o <= 32'h0000_0000;
    end else if (done_o && wr_i) begin
      wlast_o <= wdata_i;
    end
  end
  // Outside completion the data lines show the inverse, so a stale sample fails.
  assign rdata_o = done_o ? (KEY ^ {14'h0000, tag_i}) : ~(KEY ^ {14'h0000, tag_i});
endmodule
`default_nettype wire

// ### test/tb.sv
// Purpose: Self-checking bench for the configuration access decoder.
// Assumes: Two target models answer the configuration and pass-through cycles.
// Notes: Random selectors from seed 37 cover every route, abort and forward case.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic io_req_i = 1'b0, io_wr_i = 1'b0, io_ack_o, cyc_req_o, cyc_wr_o, cyc_type1_o, cyc_done_i;
  logic fwd_req_o, fwd_wr_o, fwd_done_i, cfg_access_enable_o, cfg_mabort_o, gp_mabort_o;
  logic [15:0] io_addr_i = 16'h0000, fwd_addr_o;
  logic [3:0] io_be_i = 4'h0, cyc_be_o, fwd_be_o, be;
  logic [31:0] io_wdata_i = 32'h0000_0000, io_rdata_o, cyc_addr_o, cyc_wdata_o, cyc_rdata_i;
  logic [31:0] fwd_wdata_o, fwd_rdata_i, wl_c, wl_f, sel, s, d;
  logic [1:0] cyc_tgt_o;
  logic [4:0] cyc_dev_o;
  logic [20:0] cyc_idsel_o;
  logic [7:0] fb = 8'h04, lb = 8'h09, f;
  logic [2:0] lat_c = 3'h0, lat_f = 3'h2;
  logic [33:0] got, e;
  logic [3:0] bes [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
  int err_count = 0;
  int compares = 0;
  int seed;
  pca_decoder i_pca_decoder (.*, .first_downstream_bus_index_i(fb), .last_downstream_bus_index_i(lb));
  pca_tgt_model #(.KEY(32'hC5C5_0000)) i_pca_tgt_model_cfg (.clk_sys_i, .resetn_i, .req_i(cyc_req_o),
    .wr_i(cyc_wr_o), .tag_i({cyc_be_o, cyc_tgt_o, cyc_type1_o, cyc_addr_o[10:0]}), .wdata_i(cyc_wdata_o),
    .lat_i(lat_c), .done_o(cyc_done_i), .rdata_o(cyc_rdata_i), .wlast_o(wl_c));
  pca_tgt_model #(.KEY(32'hA3A3_0000)) i_pca_tgt_model_fwd (.clk_sys_i, .resetn_i, .req_i(fwd_req_o),
    .wr_i(fwd_wr_o), .tag_i({fwd_be_o, fwd_addr_o[13:0]}), .wdata_i(fwd_wdata_o),
    .lat_i(lat_f), .done_o(fwd_done_i), .rdata_o(fwd_rdata_i), .wlast_o(wl_f));
  ////////////////////////////////////////////////////////////////////////
  // Expected {tgt, type1} of the current selector.
  function automatic logic [2:0] route(input logic [31:0] x);
    if (x[23:16] == 8'h00) return (x[15:11] <= 5'h02) ? 3'h0 : 3'h2;
    if (x[23:16] == fb) return 3'h4;
    if (x[23:16] > fb && x[23:16] <= lb) return 3'h5;
    return 3'h3;
  endfunction
  // Expected {graphics abort, abort, read data} of a host access.
  function automatic logic [33:0] expect_rd(input logic [15:0] a, input logic [3:0] b);
    logic [2:0] r;
    r = route(sel);
    if (a == 16'h0CF8 && b == 4'hF) return {2'b00, sel};
    if (a != 16'h0CFC || !sel[31]) return {2'b00, 32'hA3A3_0000 ^ {14'h0, b, a[13:0]}};
    if (r == 3'h0 && sel[10:8] != 3'h0) return {2'b01, 32'hFFFF_FFFF};
    if (r == 3'h4 && sel[15:11] > 5'h0F) return {2'b11, 32'hFFFF_FFFF};
    return {2'b00, 32'hC5C5_0000 ^ {14'h0, b, r, sel[10:2], 1'b0, r[0]}};
  endfunction
  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [33:0] g, input logic [33:0] x);
    compares++;
    if (g !== x) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic summarize();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // One host I/O cycle, held until acknowledge is sampled high.
  task automatic op(input logic w, input logic [15:0] a, input logic [3:0] b, input logic [31:0] x);
    int n;
    @(posedge clk_sys_i);
    io_req_i <= 1'b1;
    io_wr_i <= w;
    io_addr_i <= a;
    io_be_i <= b;
    io_wdata_i <= x;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (io_ack_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_count++;
      summarize();
    end
    got = {gp_mabort_o, cfg_mabort_o, io_rdata_o};
    @(posedge clk_sys_i);
    io_req_i <= 1'b0;
  endtask
  // Clock at 40 MHz.
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // Main sequence.
  initial begin
    sel = 32'h0000_0000;
    seed = $urandom(37);
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    op(1'b0, 16'h0CF8, 4'hF, 32'h0);
    chk(got, expect_rd(16'h0CF8, 4'hF));
    op(1'b0, 16'h0080, 4'hF, 32'h0);
    chk(got, expect_rd(16'h0080, 4'hF));
    op(1'b0, 16'h0CFC, 4'h3, 32'h0);
    chk(got, expect_rd(16'h0CFC, 4'h3));
    $display("test reset done");
    for (int i = 0; i < 80; i++) begin
      f = 8'($urandom_range(8, 1));
      fb <= f;
      lb <= f + 8'($urandom_range(3, 0));
      lat_c <= 3'($urandom_range(7, 0));
      lat_f <= 3'($urandom_range(7, 0));
      s = $urandom;
      case ($urandom_range(3, 0))
        0: s[23:16] = 8'h00;
        1: s[23:16] = f;
        2: s[23:16] = f + 8'h01;
        default: ;
      endcase
      if ($urandom_range(1, 0) == 1) s[15:11] = 5'($urandom_range(3, 0));
      if ($urandom_range(1, 0) == 1) s[10:8] = 3'h0;
      s[31] = ($urandom_range(5, 0) != 0);
      op(1'b1, 16'h0CF8, 4'hF, s);
      sel = s & 32'h80FF_FFFC;
      op(1'b0, 16'h0CF8, 4'hF, 32'h0);
      chk(got, expect_rd(16'h0CF8, 4'hF));
      be = bes[$urandom_range(6, 0)];
      op(1'b0, 16'h0CF8, be, 32'h0);
      chk(got, expect_rd(16'h0CF8, be));
      op(1'b0, 16'h0CFC, be, 32'h0);
      chk(got, expect_rd(16'h0CFC, be));
      d = $urandom;
      op(1'b1, 16'h0CFC, be, d);
      e = expect_rd(16'h0CFC, be);
      chk({got[33:32], (e[33:32] != 2'b00) ? 32'h0 : (sel[31] ? wl_c : wl_f)},
        {e[33:32], (e[33:32] != 2'b00) ? 32'h0 : d});
    end
    $display("test route done");
    summarize();
  end
endmodule
`default_nettype wire
